// ==== rtl/oscc_top.sv ====
// Operating state status and first sensor control registers
//
// Functional notes
// - Five-bit tally counts output-data periods after gate overrun flag sets.
// - Tally clears once buffer fill level reads zero.
// - Writing purge empties buffer and clears tally.
// - Buffer mode disabled code clears overrun flag and tally, without a purge pulse.
// - Standby to active transition clears buffer and tally.
// - Two-bit state code: standby, wake, sleep, triggered capture.
// - Boot into standby with strap low, wake with strap high and option.
// - Triggered capture never entered while strap pin is high.
// - Triggered capture only when second pin function select is one.
// - Triggered capture reads 11b waiting, 01b while measuring.
// - Wake output drives static polarity level on routed interrupt pin.
// - Entering wake, sleep or capture resets detector debounce counters.
// - Control register one holds reset, selftest, wires, range, active.
// - Control one resets zero, or with bits 1:0 set if strap high.
// - Gated buffer sets overrun flag if not emptied before next sample.
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/1ns
`include "oscc_defines.svh"

module oscc_top
	import oscc_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic nrst,
	// Register port
	input wire oscc_bus_t bus_req,
	output logic [7:0] rd_data,
	// Output buffer
	input wire oscc_buf_t buf_in,
	output logic buf_purge,
	// Measurement engine
	input wire logic sleep_req,
	input wire logic wake_req,
	input wire logic meas_done,
	output logic debounce_reset,
	output logic soft_reset,
	output logic [7:0] sensor_control_one,
	// Pins
	input wire logic boot_strap_pin,
	input wire logic second_interrupt_pin_in,
	output logic first_interrupt_pin_out,
	output logic first_interrupt_pin_oe,
	output logic second_interrupt_pin_out,
	output logic second_interrupt_pin_oe,
	// Interrupt
	output logic irq
);

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	logic [1:0] pin_sync;
	logic strap_sync;
	logic trig_level;

	oscc_sync #(.WIDTH(2)) u_sync (
		.ref_clk(ref_clk),
		.nrst(nrst),
		.async_in({boot_strap_pin, second_interrupt_pin_in}),
		.sync_out(pin_sync)
	);

	assign strap_sync = pin_sync[1];
	assign trig_level = pin_sync[0];

	// ----------------------------------------
	// State declarations
	// ----------------------------------------
	logic boot_pend_reg, boot_pend_next;
	logic [1:0] boot_cnt_reg, boot_cnt_next;
	logic [7:0] ctrl1_reg, ctrl1_next;
	logic [7:0] opt_reg, opt_next;
	logic [7:0] aux_reg, aux_next;
	logic [7:0] mask_reg, mask_next;
	logic [3:0] stat_reg, stat_next;
	oscc_state_t state_reg, state_next;
	logic meas_reg, meas_next;
	logic trig_prev_reg;
	logic gate_reg, gate_next;
	logic [4:0] tally_reg, tally_next;
	logic [7:0] rd_next;
	logic purge_next, dbr_next, srst_next, irq_next;
	logic p1_oe_next, p2_oe_next, pin_lvl_next;
	logic wr_ok, purge_wr, rst_wr, act_entry, clear_all, trig_ok, trig_edge;
	logic [1:0] code, code_next;
	logic [3:0] ev;

	assign wr_ok = bus_req.wr && !boot_pend_reg;
	assign purge_wr = wr_ok && bus_req.addr == `OSCC_ADDR_OPT
		&& bus_req.wdata[`OSCC_OPT_PURGE];
	assign rst_wr = wr_ok && bus_req.addr == `OSCC_ADDR_CTRL1
		&& bus_req.wdata[`OSCC_CTRL1_RST];
	assign trig_edge = trig_level && !trig_prev_reg;
	// capture shows wake code while measuring
	assign code = (state_reg == OSCC_TRIG && meas_reg) ? OSCC_WAKE : state_reg;
	assign code_next = (state_next == OSCC_TRIG && meas_next) ? OSCC_WAKE : state_next;

	// ----------------------------------------
	// Boot, configuration and operating state
	// ----------------------------------------
	always_comb
	begin
		boot_pend_next = boot_pend_reg;
		boot_cnt_next = boot_cnt_reg;
		ctrl1_next = ctrl1_reg;
		opt_next = opt_reg;
		aux_next = aux_reg;
		mask_next = mask_reg;
		state_next = state_reg;
		meas_next = meas_reg;
		act_entry = 1'b0;
		// capture needs second pin as trigger
		trig_ok = opt_reg[`OSCC_OPT_FUNC_SEL] && !strap_sync;
		if (boot_pend_reg)
		begin
			boot_cnt_next = boot_cnt_reg + 2'h1;
			if (boot_cnt_reg == `OSCC_BOOT_CYCLES)
			begin
				boot_pend_next = 1'b0;
				ctrl1_next = strap_sync ? `OSCC_CTRL1_RST_VDD : `OSCC_CTRL1_RST_GND;
				// boot state from strap and option
				state_next = (strap_sync && aux_reg[`OSCC_AUX_MOT_BOOT]) ? OSCC_WAKE
					: OSCC_STANDBY;
			end
		end
		else if (rst_wr)
		begin
			// Soft reset reboots, polarity survives
			boot_pend_next = 1'b1;
			boot_cnt_next = 2'h0;
			ctrl1_next = `OSCC_CTRL1_RST_GND;
			opt_next = (opt_reg & `OSCC_OPT_KEEP) | `OSCC_OPT_RST;
			aux_next = `OSCC_AUX_RST;
			state_next = OSCC_STANDBY;
			meas_next = 1'b0;
		end
		else
		begin
			if (wr_ok && bus_req.addr == `OSCC_ADDR_CTRL1)
				ctrl1_next = bus_req.wdata;
			if (wr_ok && bus_req.addr == `OSCC_ADDR_OPT)
				opt_next = bus_req.wdata & ~(8'h01 << `OSCC_OPT_PURGE);
			if (wr_ok && bus_req.addr == `OSCC_ADDR_AUX)
				aux_next = bus_req.wdata;
			if (wr_ok && bus_req.addr == `OSCC_ADDR_IRQ_MASK)
				mask_next = bus_req.wdata;
			case (state_reg)
				OSCC_STANDBY:
					if (ctrl1_reg[`OSCC_CTRL1_ACTIVE])
					begin
						act_entry = 1'b1;
						state_next = trig_ok ? OSCC_TRIG : OSCC_WAKE;
					end
				OSCC_WAKE:
					if (!ctrl1_reg[`OSCC_CTRL1_ACTIVE])
						state_next = OSCC_STANDBY;
					else if (trig_ok)
						state_next = OSCC_TRIG;
					else if (sleep_req)
						state_next = OSCC_SLEEP;
				OSCC_SLEEP:
					if (!ctrl1_reg[`OSCC_CTRL1_ACTIVE])
						state_next = OSCC_STANDBY;
					else if (trig_ok)
						state_next = OSCC_TRIG;
					else if (wake_req)
						state_next = OSCC_WAKE;
				OSCC_TRIG:
					if (!ctrl1_reg[`OSCC_CTRL1_ACTIVE])
						state_next = OSCC_STANDBY;
					else if (!trig_ok)
						state_next = OSCC_WAKE;
					else if (trig_edge)
						meas_next = 1'b1;
					else if (meas_done)
						meas_next = 1'b0;
				default:
					state_next = OSCC_STANDBY;
			endcase
			if (state_next != OSCC_TRIG)
				meas_next = 1'b0;
		end
	end

	// Registers of the state group
	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			boot_pend_reg <= 1'b1;
			boot_cnt_reg <= 2'h0;
			ctrl1_reg <= `OSCC_CTRL1_RST_GND;
			opt_reg <= `OSCC_OPT_RST;
			aux_reg <= `OSCC_AUX_RST;
			mask_reg <= 8'h00;
			state_reg <= OSCC_STANDBY;
			meas_reg <= 1'b0;
			trig_prev_reg <= 1'b0;
		end
		else
		begin
			boot_pend_reg <= boot_pend_next;
			boot_cnt_reg <= boot_cnt_next;
			ctrl1_reg <= ctrl1_next;
			opt_reg <= opt_next;
			aux_reg <= aux_next;
			mask_reg <= mask_next;
			state_reg <= state_next;
			meas_reg <= meas_next;
			trig_prev_reg <= trig_level;
		end
	end

	// ----------------------------------------
	// Overrun flag and period tally
	// ----------------------------------------
	always_comb
	begin
		clear_all = buf_in.fill == `OSCC_FILL_EMPTY || purge_wr || act_entry
			|| opt_reg[`OSCC_OPT_MODE_LO +: 2] == `OSCC_BUF_MODE_OFF;
		gate_next = gate_reg;
		tally_next = tally_reg;
		if (opt_reg[`OSCC_OPT_GATE_EN] && buf_in.sample)
			gate_next = 1'b1;
		if (clear_all)
		begin
			gate_next = 1'b0;
			tally_next = 5'h00;
		end
		else if (gate_reg && buf_in.odr_tick && tally_reg != `OSCC_TALLY_MAX)
			tally_next = tally_reg + 5'h01;
	end

	// Registers of the overrun group
	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			gate_reg <= 1'b0;
			tally_reg <= 5'h00;
		end
		else
		begin
			gate_reg <= gate_next;
			tally_reg <= tally_next;
		end
	end

	// ----------------------------------------
	// Read data, events, pins and pulses
	// ----------------------------------------
	always_comb
	begin
		rd_next = 8'h00;
		if (bus_req.rd)
		begin
			if (bus_req.addr == `OSCC_ADDR_STATUS)
				rd_next = {gate_reg, tally_reg, code};
			else if (bus_req.addr == `OSCC_ADDR_CTRL1)
				rd_next = ctrl1_reg & ~(8'h01 << `OSCC_CTRL1_RST);
			else if (bus_req.addr == `OSCC_ADDR_OPT)
				rd_next = opt_reg;
			else if (bus_req.addr == `OSCC_ADDR_AUX)
				rd_next = aux_reg;
			else if (bus_req.addr == `OSCC_ADDR_IRQ_STAT)
				rd_next = {4'h0, stat_reg};
			else if (bus_req.addr == `OSCC_ADDR_IRQ_MASK)
				rd_next = mask_reg;
		end
		ev[`OSCC_IRQ_GATE] = gate_next && !gate_reg;
		ev[`OSCC_IRQ_SAT] = tally_next == `OSCC_TALLY_MAX && tally_reg != `OSCC_TALLY_MAX;
		ev[`OSCC_IRQ_STATE] = code_next != code;
		ev[`OSCC_IRQ_TRIG] = trig_edge && state_reg == OSCC_TRIG;
		// Write-one clear, a new event wins
		stat_next = stat_reg;
		if (wr_ok && bus_req.addr == `OSCC_ADDR_IRQ_STAT)
			stat_next = stat_reg & ~bus_req.wdata[3:0];
		stat_next = stat_next | ev;
		irq_next = |(stat_next & mask_next[3:0]);
		purge_next = purge_wr || act_entry;
		dbr_next = state_next != state_reg && state_next != OSCC_STANDBY;
		srst_next = rst_wr;
		// wake output on the routed pin
		p1_oe_next = opt_next[`OSCC_OPT_WAKE_EN] && code_next == OSCC_WAKE
			&& !opt_next[`OSCC_OPT_ROUTE];
		p2_oe_next = opt_next[`OSCC_OPT_WAKE_EN] && code_next == OSCC_WAKE
			&& opt_next[`OSCC_OPT_ROUTE] && !opt_next[`OSCC_OPT_FUNC_SEL];
		pin_lvl_next = opt_next[`OSCC_OPT_POL];
	end

	// Registers of the output group
	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			rd_data <= 8'h00;
			stat_reg <= 4'h0;
			irq <= 1'b0;
			buf_purge <= 1'b0;
			debounce_reset <= 1'b0;
			soft_reset <= 1'b0;
			first_interrupt_pin_oe <= 1'b0;
			first_interrupt_pin_out <= 1'b0;
			second_interrupt_pin_oe <= 1'b0;
			second_interrupt_pin_out <= 1'b0;
		end
		else
		begin
			rd_data <= rd_next;
			stat_reg <= stat_next;
			irq <= irq_next;
			buf_purge <= purge_next;
			debounce_reset <= dbr_next;
			soft_reset <= srst_next;
			first_interrupt_pin_oe <= p1_oe_next;
			first_interrupt_pin_out <= p1_oe_next && pin_lvl_next;
			second_interrupt_pin_oe <= p2_oe_next;
			second_interrupt_pin_out <= p2_oe_next && pin_lvl_next;
		end
	end

	assign sensor_control_one = ctrl1_reg;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	property p_tally_inc;
		@(posedge ref_clk) disable iff (!nrst)
		gate_reg && buf_in.odr_tick && !clear_all && tally_reg != `OSCC_TALLY_MAX
		|=> tally_reg == $past(tally_reg) + 5'h01;
	endproperty
	a_tally_inc: assert property (p_tally_inc) else $error("tally did not count");

	property p_drain_clear;
		@(posedge ref_clk) disable iff (!nrst)
		buf_in.fill == `OSCC_FILL_EMPTY |=> tally_reg == 5'h00 && !gate_reg;
	endproperty
	a_drain_clear: assert property (p_drain_clear) else $error("drain left tally");

	property p_purge;
		@(posedge ref_clk) disable iff (!nrst)
		purge_wr |=> buf_purge && tally_reg == 5'h00
			##1 buf_purge == ($past(purge_wr) || $past(act_entry));
	endproperty
	a_purge: assert property (p_purge) else $error("purge not applied");

	property p_mode_off;
		@(posedge ref_clk) disable iff (!nrst)
		opt_reg[`OSCC_OPT_MODE_LO +: 2] == `OSCC_BUF_MODE_OFF |=> tally_reg == 5'h00;
	endproperty
	a_mode_off: assert property (p_mode_off) else $error("disabled mode kept tally");

	property p_act_entry;
		@(posedge ref_clk) disable iff (!nrst)
		state_reg == OSCC_STANDBY ##1 state_reg != OSCC_STANDBY && !$past(boot_pend_reg)
		|-> buf_purge && tally_reg == 5'h00;
	endproperty
	a_act_entry: assert property (p_act_entry) else $error("activation kept data");

	property p_code_read;
		@(posedge ref_clk) disable iff (!nrst)
		bus_req.rd && bus_req.addr == `OSCC_ADDR_STATUS |=> rd_data[1:0] == $past(code);
	endproperty
	a_code_read: assert property (p_code_read) else $error("wrong state code");

	property p_no_trig_strap;
		@(posedge ref_clk) disable iff (!nrst)
		strap_sync && state_reg != OSCC_TRIG |=> state_reg != OSCC_TRIG;
	endproperty
	a_no_trig_strap: assert property (p_no_trig_strap) else $error("capture with strap");

	property p_measure_code;
		@(posedge ref_clk) disable iff (!nrst)
		state_reg == OSCC_TRIG && trig_edge && trig_ok
			&& ctrl1_reg[`OSCC_CTRL1_ACTIVE] && !rst_wr
		|=> code == OSCC_WAKE;
	endproperty
	a_measure_code: assert property (p_measure_code) else $error("capture code wrong");

	property p_wake_pin;
		@(posedge ref_clk) disable iff (!nrst)
		opt_reg[`OSCC_OPT_WAKE_EN] && code == OSCC_WAKE && !opt_reg[`OSCC_OPT_ROUTE]
		|-> first_interrupt_pin_oe && first_interrupt_pin_out == opt_reg[`OSCC_OPT_POL];
	endproperty
	a_wake_pin: assert property (p_wake_pin) else $error("wake level missing");

	property p_debounce;
		@(posedge ref_clk) disable iff (!nrst)
		state_reg != $past(state_reg) && state_reg != OSCC_STANDBY |-> debounce_reset;
	endproperty
	a_debounce: assert property (p_debounce) else $error("no debounce reset");

	property p_sat;
		@(posedge ref_clk) disable iff (!nrst)
		tally_reg == `OSCC_TALLY_MAX && !clear_all |=> tally_reg == `OSCC_TALLY_MAX;
	endproperty
	a_sat: assert property (p_sat) else $error("tally wrapped");

endmodule // oscc_top

// ==== rtl/oscc_defines.svh ====
// Offsets, field positions, reset values and counts of the operating state block
`ifndef OSCC_DEFINES_SVH
`define OSCC_DEFINES_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define OSCC_ADDR_STATUS 8'h14
`define OSCC_ADDR_CTRL1 8'h15
`define OSCC_ADDR_OPT 8'h40
`define OSCC_ADDR_AUX 8'h41
`define OSCC_ADDR_IRQ_STAT 8'h42
`define OSCC_ADDR_IRQ_MASK 8'h43

// ----------------------------------------
// Field positions
// ----------------------------------------
`define OSCC_CTRL1_RST 7
`define OSCC_CTRL1_ACTIVE 0
`define OSCC_OPT_GATE_EN 0
`define OSCC_OPT_PURGE 1
`define OSCC_OPT_MODE_LO 2
`define OSCC_OPT_FUNC_SEL 4
`define OSCC_OPT_WAKE_EN 5
`define OSCC_OPT_ROUTE 6
`define OSCC_OPT_POL 7
`define OSCC_AUX_MOT_BOOT 0
`define OSCC_IRQ_GATE 0
`define OSCC_IRQ_SAT 1
`define OSCC_IRQ_STATE 2
`define OSCC_IRQ_TRIG 3

// ----------------------------------------
// Reset values and counts
// ----------------------------------------
`define OSCC_CTRL1_RST_GND 8'h00
`define OSCC_CTRL1_RST_VDD 8'h03
`define OSCC_OPT_RST 8'h00
`define OSCC_OPT_KEEP 8'h80
`define OSCC_AUX_RST 8'h01
`define OSCC_TALLY_MAX 5'h1f
`define OSCC_BOOT_CYCLES 2'h3
`define OSCC_BUF_MODE_OFF 2'h0
`define OSCC_FILL_EMPTY 6'h00

`endif

// ==== rtl/oscc_pkg.sv ====
// Types shared by the operating state block
package oscc_pkg;

	// Operating state, values equal the reported codes
	typedef enum logic [1:0] {
		OSCC_STANDBY = 2'h0,
		OSCC_WAKE = 2'h1,
		OSCC_TRIG = 2'h3,
		OSCC_SLEEP = 2'h2
	} oscc_state_t;

	// Register port request
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} oscc_bus_t;

	// Output buffer status
	typedef struct packed {
		logic [5:0] fill;
		logic sample;
		logic odr_tick;
	} oscc_buf_t;

endpackage

// ==== rtl/oscc_sync.sv ====
// Two-stage synchroniser for pin inputs
`timescale 1ns/1ns

module oscc_sync
#(
	parameter int WIDTH = 2
)
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic nrst,
	// Pins and synchronised levels
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] meta_reg;

	// ----------------------------------------
	// Per-bit stages
	// ----------------------------------------
	genvar i;
	generate
		for (i = 0; i < WIDTH; i++)
		begin : g_bit
			// First stage read only by the second
			always_ff @(posedge ref_clk or negedge nrst)
			begin
				if (!nrst)
				begin
					meta_reg[i] <= 1'b0;
					sync_out[i] <= 1'b0;
				end
				else
				begin
					meta_reg[i] <= async_in[i];
					sync_out[i] <= meta_reg[i];
				end
			end
		end
	endgenerate

endmodule // oscc_sync

// ==== verification/oscc_host.sv ====
// Host processor model driving the register port
`timescale 1ns/1ns

module oscc_host
	import oscc_pkg::*;
(
	// Clock
	input wire logic ref_clk,
	// Register port request
	output oscc_bus_t bus_req
);
	// ----------------------------------------
	// Bus cycles
	// ----------------------------------------
	initial bus_req = '0;

	// One-cycle write strobe beside address and data
	task automatic write(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge ref_clk);
		bus_req.wr <= 1'b0;
	endtask

	// One-cycle read strobe, data sampled by the bench monitor
	task automatic read(input logic [7:0] a);
		@(posedge ref_clk);
		bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge ref_clk);
		bus_req.rd <= 1'b0;
	endtask
endmodule // oscc_host

// ==== verification/oscc_top_test.sv ====
// Self-checking bench of the operating state block
`timescale 1ns/1ns

`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin errors++; \
	$display("[ERR] %0t got %h want %h", $time, a, b); end end

module oscc_top_test
	import oscc_pkg::*;
;
	// ----------------------------------------
	// Signals
	// ----------------------------------------
	logic ref_clk = 1'b0;
	logic nrst = 1'b0;
	oscc_bus_t bus_req;
	logic [7:0] rd_data;
	oscc_buf_t buf_in = '0;
	logic buf_purge, debounce_reset, soft_reset, irq;
	logic sleep_req = 1'b0, wake_req = 1'b0, meas_done = 1'b0;
	logic [7:0] sensor_control_one;
	logic boot_strap_pin = 1'b0, second_interrupt_pin_in = 1'b0;
	logic first_interrupt_pin_out, first_interrupt_pin_oe;
	logic second_interrupt_pin_out, second_interrupt_pin_oe;
	int errors = 0, check_count = 0, pg_n = 0, db_n = 0, sr_n = 0, seed = 36989;
	logic [7:0] exp_q[$];
	logic [7:0] v;
	logic [7:0] exp_v;
	logic rd_d = 1'b0;

	// ----------------------------------------
	// Instances
	// ----------------------------------------
	oscc_top dut (.ref_clk(ref_clk), .nrst(nrst), .bus_req(bus_req), .rd_data(rd_data),
		.buf_in(buf_in), .buf_purge(buf_purge), .sleep_req(sleep_req), .wake_req(wake_req),
		.meas_done(meas_done), .debounce_reset(debounce_reset), .soft_reset(soft_reset),
		.sensor_control_one(sensor_control_one), .boot_strap_pin(boot_strap_pin),
		.second_interrupt_pin_in(second_interrupt_pin_in),
		.first_interrupt_pin_out(first_interrupt_pin_out),
		.first_interrupt_pin_oe(first_interrupt_pin_oe),
		.second_interrupt_pin_out(second_interrupt_pin_out),
		.second_interrupt_pin_oe(second_interrupt_pin_oe), .irq(irq));
	oscc_host host (.ref_clk(ref_clk), .bus_req(bus_req));

	// Clock
	initial forever #5 ref_clk = ~ref_clk;

	// ----------------------------------------
	// Monitor and helpers
	// ----------------------------------------
	// Read data compared in the cycle after the strobe, pulses counted
	always @(posedge ref_clk) begin
		rd_d <= bus_req.rd;
		if (buf_purge === 1'b1) pg_n++;
		if (debounce_reset === 1'b1) db_n++;
		if (soft_reset === 1'b1) sr_n++;
	end
	// Oldest expected read value taken once per answered read
	always @(negedge ref_clk)
		if (rd_d)
		begin
			exp_v = exp_q.pop_front();
			`CHK(rd_data, exp_v)
		end

	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		host.read(a);
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
	endtask
	task automatic odr(input int n);
		repeat (n) begin
			@(posedge ref_clk) buf_in.odr_tick <= 1'b1;
			@(posedge ref_clk) buf_in.odr_tick <= 1'b0;
		end
	endtask
	task automatic smp();
		@(posedge ref_clk) buf_in.sample <= 1'b1;
		@(posedge ref_clk) buf_in.sample <= 1'b0;
	endtask
	task automatic results();
		$display("checks %0d mismatches %0d", check_count, errors);
		if (errors == 0 && check_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// Watchdog
	initial
	begin
		#50000;
		errors++;
		results();
	end

	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial
	begin
		tick(10);
		nrst <= 1'b1;
		tick(8);
		rd(8'h14, 8'h00);
		rd(8'h15, 8'h00);
		rd(8'h20, 8'h00);
		v = 8'($random(seed));
		host.write(8'h15, v & 8'h7e);
		rd(8'h15, v & 8'h7e);
		host.write(8'h15, 8'h00);
		$display("reset and control done");
		// Activation from standby: wake, purge and debounce pulses
		host.write(8'h15, 8'h01);
		tick(3);
		rd(8'h14, 8'h01);
		`CHK(pg_n, 1)
		`CHK(db_n, 1)
		// Overrun flag and tally, drain clear
		host.write(8'h40, 8'h05);
		buf_in.fill <= 6'h03;
		smp();
		odr(3);
		rd(8'h14, 8'h8d);
		odr(30);
		rd(8'h14, 8'hfd);
		buf_in.fill <= 6'h00;
		tick(2);
		rd(8'h14, 8'h01);
		// Purge and disable clears
		buf_in.fill <= 6'h02;
		smp();
		odr(2);
		host.write(8'h40, 8'h07);
		tick(2);
		rd(8'h14, 8'h01);
		`CHK(pg_n, 2)
		buf_in.fill <= 6'h02;
		host.write(8'h40, 8'h05);
		smp();
		odr(2);
		host.write(8'h40, 8'h01);
		tick(2);
		rd(8'h14, 8'h01);
		buf_in.fill <= 6'h00;
		$display("overrun tally done");
		// Interrupt raised, masked and cleared
		host.write(8'h42, 8'h0f);
		host.write(8'h43, 8'h00);
		buf_in.fill <= 6'h02;
		host.write(8'h40, 8'h05);
		smp();
		tick(2);
		`CHK(irq, 1'b0)
		rd(8'h14, 8'h81);
		rd(8'h42, 8'h01);
		host.write(8'h43, 8'h01);
		tick(2);
		`CHK(irq, 1'b1)
		host.write(8'h42, 8'h01);
		tick(2);
		`CHK(irq, 1'b0)
		buf_in.fill <= 6'h00;
		$display("interrupt done");
		// Wake output on both pins, both levels on the first pin
		host.write(8'h40, 8'ha0);
		tick(2);
		`CHK({first_interrupt_pin_oe, first_interrupt_pin_out, second_interrupt_pin_oe}, 3'b110)
		host.write(8'h40, 8'he0);
		tick(2);
		`CHK({second_interrupt_pin_oe, second_interrupt_pin_out, first_interrupt_pin_oe}, 3'b110)
		host.write(8'h40, 8'h20);
		tick(2);
		`CHK({first_interrupt_pin_oe, first_interrupt_pin_out}, 2'b10)
		host.write(8'h40, 8'h00);
		// Sleep and wake transitions
		@(posedge ref_clk) sleep_req <= 1'b1;
		@(posedge ref_clk) sleep_req <= 1'b0;
		tick(2);
		rd(8'h14, 8'h02);
		@(posedge ref_clk) wake_req <= 1'b1;
		@(posedge ref_clk) wake_req <= 1'b0;
		tick(2);
		rd(8'h14, 8'h01);
		`CHK(db_n, 3)
		$display("wake output and sleep done");
		// Triggered capture with strap low
		host.write(8'h15, 8'h00);
		tick(3);
		rd(8'h14, 8'h00);
		host.write(8'h40, 8'h10);
		host.write(8'h15, 8'h01);
		tick(3);
		rd(8'h14, 8'h03);
		@(posedge ref_clk) second_interrupt_pin_in <= 1'b1;
		tick(4);
		rd(8'h14, 8'h01);
		@(posedge ref_clk) meas_done <= 1'b1;
		@(posedge ref_clk) meas_done <= 1'b0;
		second_interrupt_pin_in <= 1'b0;
		tick(2);
		rd(8'h14, 8'h03);
		$display("capture done");
		// Soft reset with strap high, capture refused
		boot_strap_pin <= 1'b1;
		tick(3);
		host.write(8'h15, 8'h80);
		tick(8);
		rd(8'h15, 8'h03);
		rd(8'h14, 8'h01);
		`CHK(sensor_control_one, 8'h03)
		`CHK(sr_n, 1)
		host.write(8'h15, 8'h00);
		host.write(8'h40, 8'h10);
		host.write(8'h15, 8'h01);
		tick(3);
		rd(8'h14, 8'h01);
		tick(3);
		$display("soft reset done");
		results();
	end
endmodule // oscc_top_test
